/* core/sup_pkg.sv */
// package: constants and types for the supply supervisor event masking block
// Operation
// [R1] fast-mode comparator start masks fault events for about 2 us
// [R2] mask length chosen from fast or normal mode at enable time; here power-up clear and power-on reset always load the normal mask
// [R3] unmasked fault sets side flag; reset-enable adds a power-on reset
// [R4] any fault flag set holds all gpio outputs in high impedance; here only while its side has not settled or a reset request stands
// [R5] keep-on 0: comparators off in deep sleep, back on with new mask
// [R6] after power-up clear or power-on reset, enable supervisors and start mask
// [R7] keep-on 1: comparators stay running through deep sleep
// [R8] normal mode settling delay is about 150 us
// [R9] per-side delay-expired flag raised at mask end, cleared by software write
`default_nettype none
package sup_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned FAST_MASK_NS = 2000;
  localparam int unsigned NORM_MASK_US = 150;
  localparam int unsigned FAST_MASK_CYC = (FAST_MASK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NORM_MASK_CYC = NORM_MASK_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned POR_PULSE_CYC = 4;
  localparam int unsigned SIDE_HI = 1;
  localparam int unsigned SIDE_LO = 0;

  // state of one side's comparator
  typedef enum logic [1:0] {
    SUP_OFF,
    SUP_MASK,
    SUP_RUN
  } sup_mode_t;

  // per-side configuration bits
  typedef struct packed {
    logic enable;
    logic fast_mode;
    logic reset_enable;
    logic lowpower_keep_on;
  } sup_cfg_t;

  // one side's state
  typedef struct packed {
    sup_mode_t mode;
    logic [CNT_W-1:0] cnt;
    logic fault_flag;
    logic dly_flag;
    logic active;
  } sup_side_t;

  // whole block state
  typedef struct packed {
    sup_side_t [1:0] side;
    logic [2:0] por_cnt;
    logic por_req;
    logic gpio_hiz;
  } sup_state_t;
endpackage
`default_nettype wire

/* core/sup_supervisor.sv */
// module: supply supervisor masking, fault flags, reset request, gpio tri-state
`timescale 1ns/1ps
`default_nettype none
module sup_supervisor #(
  parameter int unsigned NORM_CYC = sup_pkg::NORM_MASK_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic soft_power_up_clear,
  input wire logic deep_sleep_modes,
  input wire sup_pkg::sup_cfg_t [1:0] cfg,
  input wire logic [1:0] comparator_fault,
  input wire logic [1:0] supervisor_fault_flag_clr,
  input wire logic [1:0] delay_expired_flag_clr,
  output logic [1:0] supervisor_fault_flag,
  output logic [1:0] delay_expired_flag,
  output logic [1:0] comparator_on,
  output logic power_on_reset_req,
  output logic gpio_hiz
);
  sup_pkg::sup_state_t st, next_st;

  // next-state logic for both sides
  always_comb begin
    logic off_req;
    logic hit;
    logic dly_set;
    logic por_load;
    logic por_done;
    off_req = 1'b0;
    hit = 1'b0;
    dly_set = 1'b0;
    por_load = 1'b0;
    por_done = 1'b0;
    next_st = st;
    for (int i = 0; i < 2; i++) begin
      // keep-on chooses whether deep sleep stops the comparator
      off_req = !cfg[i].enable || (deep_sleep_modes && !cfg[i].lowpower_keep_on); // [R5] [R7]
      dly_set = 1'b0;
      unique case (st.side[i].mode)
        sup_pkg::SUP_OFF: begin
          if (!off_req) begin
            // restart mask on enable or sleep exit, length from mode now
            next_st.side[i].mode = sup_pkg::SUP_MASK; // [R5]
            next_st.side[i].cnt = cfg[i].fast_mode ? sup_pkg::CNT_W'(sup_pkg::FAST_MASK_CYC)
                                                   : sup_pkg::CNT_W'(NORM_CYC); // [R1] [R2] [R8]
          end
        end
        sup_pkg::SUP_MASK: begin
          if (off_req) begin
            next_st.side[i].mode = sup_pkg::SUP_OFF;
          end else if (st.side[i].cnt <= sup_pkg::CNT_W'(1)) begin
            next_st.side[i].mode = sup_pkg::SUP_RUN;
            next_st.side[i].cnt = '0;
            dly_set = 1'b1; // [R9]
          end else begin
            next_st.side[i].cnt = st.side[i].cnt - sup_pkg::CNT_W'(1);
          end
        end
        sup_pkg::SUP_RUN: begin
          // disable, or sleep without keep-on, stops a settled comparator
          if (off_req) begin
            next_st.side[i].mode = sup_pkg::SUP_OFF;
          end
        end
        default: begin
          // unused code: drop to off, the next cycle restarts the mask
          next_st.side[i].mode = sup_pkg::SUP_OFF;
        end
      endcase
      next_st.side[i].active = (next_st.side[i].mode != sup_pkg::SUP_OFF);
      // set wins over software clear
      hit = (st.side[i].mode == sup_pkg::SUP_RUN) && comparator_fault[i] && !off_req; // [R3]
      // software clears first, hardware sets of the same cycle win
      if (delay_expired_flag_clr[i]) begin
        next_st.side[i].dly_flag = 1'b0; // [R9]
      end
      if (dly_set) begin
        next_st.side[i].dly_flag = 1'b1; // [R9]
      end
      if (supervisor_fault_flag_clr[i]) begin
        next_st.side[i].fault_flag = 1'b0;
      end
      if (hit) begin
        next_st.side[i].fault_flag = 1'b1; // [R3]
        if (cfg[i].reset_enable) begin
          next_st.por_cnt = 3'(sup_pkg::POR_PULSE_CYC); // [R3]
          por_load = 1'b1;
        end
      end
    end
    // reset pulse counts down; its last cycle restarts both masks
    if (!por_load && st.por_cnt != 3'h0) begin
      next_st.por_cnt = st.por_cnt - 3'h1;
      por_done = (st.por_cnt == 3'h1);
    end
    next_st.por_req = (next_st.por_cnt != 3'h0);
    if (soft_power_up_clear || por_done) begin
      // power-up clear or internal reset: supervisors on, mask restarts, flags kept
      for (int i = 0; i < 2; i++) begin
        next_st.side[i].mode = sup_pkg::SUP_MASK; // [R6]
        next_st.side[i].cnt = sup_pkg::CNT_W'(NORM_CYC); // [R6]
        next_st.side[i].active = 1'b1;
      end
    end
    // tri-state while a flag stands and its comparator has not settled, or while any flag and the reset request stand
    next_st.gpio_hiz = (next_st.side[1].fault_flag && next_st.side[1].mode != sup_pkg::SUP_RUN)
                    || (next_st.side[0].fault_flag && next_st.side[0].mode != sup_pkg::SUP_RUN)
                    || ((next_st.side[1].fault_flag || next_st.side[0].fault_flag)
                        && next_st.por_req); // [R4]
  end

  // state register; reset enables both sides in normal-mode mask
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
      st.side[0].mode <= sup_pkg::SUP_MASK; // [R6]
      st.side[1].mode <= sup_pkg::SUP_MASK; // [R6]
      st.side[0].cnt <= sup_pkg::CNT_W'(NORM_CYC);
      st.side[1].cnt <= sup_pkg::CNT_W'(NORM_CYC);
      st.side[0].active <= 1'b1;
      st.side[1].active <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign supervisor_fault_flag = {st.side[1].fault_flag, st.side[0].fault_flag};
  assign delay_expired_flag = {st.side[1].dly_flag, st.side[0].dly_flag};
  assign comparator_on = {st.side[1].active, st.side[0].active};
  assign power_on_reset_req = st.por_req;
  assign gpio_hiz = st.gpio_hiz;

  a_fault_sets_flag: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    st.side[0].mode == sup_pkg::SUP_RUN && comparator_fault[0] && cfg[0].enable
    && !deep_sleep_modes && !soft_power_up_clear |=> supervisor_fault_flag[0] || !resetn)
    else $error("fault did not set flag");
  a_mask_no_fault: assert property (@(posedge clk) disable iff (!resetn) // [R1]
    st.side[1].mode == sup_pkg::SUP_MASK && !supervisor_fault_flag[1] |=> !supervisor_fault_flag[1])
    else $error("fault flagged during mask");
  a_fast_mask_len: assert property (@(posedge clk) disable iff (!resetn) // [R2]
    st.side[0].mode == sup_pkg::SUP_OFF && cfg[0].enable && cfg[0].fast_mode
    && !deep_sleep_modes && !soft_power_up_clear && !power_on_reset_req
    |=> st.side[0].cnt == sup_pkg::CNT_W'(sup_pkg::FAST_MASK_CYC))
    else $error("fast mask length wrong");
  a_sleep_off: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    deep_sleep_modes && !cfg[0].lowpower_keep_on && !soft_power_up_clear && !st.por_req
    |=> !comparator_on[0])
    else $error("comparator left on in sleep");
  a_keep_on: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    comparator_on[1] && cfg[1].enable && cfg[1].lowpower_keep_on && $stable(cfg[1].enable)
    |=> comparator_on[1])
    else $error("keep-on comparator switched off");
  a_puc_mask: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    soft_power_up_clear |=> st.side[0].mode == sup_pkg::SUP_MASK || st.por_req)
    else $error("no mask after power-up clear");
  a_hiz_flag: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    gpio_hiz |-> |supervisor_fault_flag)
    else $error("gpio tri-stated with no flag");
  a_dly_flag: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    st.side[0].mode == sup_pkg::SUP_MASK ##1 st.side[0].mode == sup_pkg::SUP_RUN
    |-> delay_expired_flag[0])
    else $error("delay flag not raised");
  c_mask_done: cover property (@(posedge clk) $rose(delay_expired_flag[1]));
  c_fault: cover property (@(posedge clk) $rose(supervisor_fault_flag[0]));
  c_por: cover property (@(posedge clk) $rose(power_on_reset_req));

  // flag clear takes effect when no fault arrives in the same cycle
  a_fault_clear: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    supervisor_fault_flag_clr[0] && !comparator_fault[0] |=> !supervisor_fault_flag[0])
    else $error("fault flag not cleared");
  // a reset-enabled side asks for a power-on reset on a fault
  a_fault_por: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    st.side[1].mode == sup_pkg::SUP_RUN && comparator_fault[1] && cfg[1].enable
    && cfg[1].reset_enable && !deep_sleep_modes |=> power_on_reset_req)
    else $error("no reset request on fault");
  // no reset request starts while no side has its reset enabled
  a_por_cause: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    !power_on_reset_req && !cfg[0].reset_enable && !cfg[1].reset_enable
    |=> !power_on_reset_req)
    else $error("reset request without enable");
  // reset request stands for the whole pulse
  a_por_pulse: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    $rose(power_on_reset_req) |-> power_on_reset_req[*4])
    else $error("reset request pulse too short");
  // normal-mode enable loads the long mask
  a_norm_mask_len: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    st.side[1].mode == sup_pkg::SUP_OFF && cfg[1].enable && !cfg[1].fast_mode
    && !deep_sleep_modes && !power_on_reset_req
    |=> st.side[1].cnt == sup_pkg::CNT_W'(NORM_CYC))
    else $error("normal mask length wrong");
  // high-side fast-mode enable loads the short mask
  a_fast_mask_hi: assert property (@(posedge clk) disable iff (!resetn) // [R1]
    st.side[1].mode == sup_pkg::SUP_OFF && cfg[1].enable && cfg[1].fast_mode
    && !deep_sleep_modes && !soft_power_up_clear && !power_on_reset_req
    |=> st.side[1].cnt == sup_pkg::CNT_W'(sup_pkg::FAST_MASK_CYC))
    else $error("high-side fast mask length wrong");
  // a switched-off comparator raises no fault
  a_off_no_fault: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    st.side[0].mode == sup_pkg::SUP_OFF && !supervisor_fault_flag[0]
    |=> !supervisor_fault_flag[0])
    else $error("fault flagged while off");
  // unsettled side with a flag keeps gpio tri-stated
  a_hiz_unsettled: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (supervisor_fault_flag[0] && st.side[0].mode != sup_pkg::SUP_RUN)
    || (supervisor_fault_flag[1] && st.side[1].mode != sup_pkg::SUP_RUN) |-> gpio_hiz)
    else $error("gpio not tri-stated");
  // delay flag clear away from the mask end
  a_dly_clear: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    delay_expired_flag_clr[1] && st.side[1].mode != sup_pkg::SUP_MASK
    |=> !delay_expired_flag[1])
    else $error("delay flag not cleared");
  // high-side mask end raises its delay flag, even against a clear
  a_dly_flag_hi: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    st.side[1].mode == sup_pkg::SUP_MASK ##1 st.side[1].mode == sup_pkg::SUP_RUN
    |-> delay_expired_flag[1])
    else $error("high-side delay flag not raised");
  // keep-on holds the low side through sleep
  a_keep_on_lo: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    comparator_on[0] && cfg[0].enable && cfg[0].lowpower_keep_on |=> comparator_on[0])
    else $error("low-side keep-on comparator switched off");
  // further scenarios of interest
  c_hiz: cover property (@(posedge clk) $rose(gpio_hiz));
  c_keep_sleep: cover property (@(posedge clk) deep_sleep_modes && comparator_on == 2'h3);
endmodule
`default_nettype wire

/* dv/tb_sup_supervisor.sv */
// testbench for the supply supervisor event masking block
`timescale 1ns/1ps
`default_nettype none
module tb_sup_supervisor;
  localparam int unsigned NC = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pclr = 1'b0;
  logic sleep = 1'b0;
  sup_pkg::sup_cfg_t [1:0] cfg = {4'h8, 4'h8};
  logic [1:0] fault = 2'h0;
  logic [1:0] fclr = 2'h0;
  logic [1:0] dclr = 2'h0;
  logic [1:0] fflag, dflag, con;
  logic por, hiz;
  int n_fail = 0;
  int n_tests = 0;
  // clock
  always #10 clk = ~clk;
  sup_supervisor #(.NORM_CYC(NC)) dut_u (.clk(clk), .resetn(resetn),
    .soft_power_up_clear(pclr), .deep_sleep_modes(sleep), .cfg(cfg),
    .comparator_fault(fault), .supervisor_fault_flag_clr(fclr),
    .delay_expired_flag_clr(dclr), .supervisor_fault_flag(fflag),
    .delay_expired_flag(dflag), .comparator_on(con), .power_on_reset_req(por),
    .gpio_hiz(hiz));
  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for delay flags, with an earliest allowed cycle
  task automatic wait_dly(input logic [1:0] want, input int lo, input int hi);
    int i;
    i = 0;
    while ((dflag & want) !== want && i < hi) begin
      step(1);
      i++;
    end
    if (i >= hi) begin
      n_fail++;
      stop_test();
    end else begin
      chk(i >= lo, 8'h1);
      dclr = 2'h3;
      step(1);
      dclr = 2'h0;
      chk(dflag, 8'h0);
    end
  endtask
  // reset values, faults ignored while the first mask runs
  task automatic t_reset();
    chk({fflag, dflag, con, por, hiz}, 8'h0c);
    fault = 2'h3;
    step(5);
    fault = 2'h0;
    chk(fflag, 8'h0);
    wait_dly(2'h3, NC - 8, NC + 5);
  endtask
  // fault flags, reset request and gpio tri-state
  task automatic t_fault();
    fault = 2'h1;
    step(1);
    chk({fflag, por}, 8'h2);
    fclr = 2'h1;
    step(1);
    chk(fflag, 8'h1);
    fault = 2'h0;
    step(1);
    fclr = 2'h0;
    chk(fflag, 8'h0);
    cfg[1] = 4'ha;
    fault = 2'h2;
    step(1);
    fault = 2'h0;
    chk({fflag, por, hiz}, 8'hb);
    step(3);
    chk(por, 8'h1);
    step(1);
    chk({fflag, por, hiz}, 8'h9);
    wait_dly(2'h3, NC - 6, NC + 6);
    fclr = 2'h2;
    cfg[1] = 4'h8;
    step(1);
    fclr = 2'h0;
    chk({fflag, hiz}, 8'h0);
  endtask
  // fast and normal mask lengths chosen at enable
  task automatic t_mode();
    cfg[0] = 4'h0;
    step(2);
    chk(con, 8'h2);
    cfg[0] = 4'hc;
    wait_dly(2'h1, 95, 106);
    cfg[0] = 4'h0;
    step(2);
    cfg[0] = 4'h8;
    wait_dly(2'h1, NC - 3, NC + 5);
  endtask
  // deep sleep with keep-on clear and set
  task automatic t_sleep();
    sleep = 1'b1;
    step(3);
    chk(con, 8'h0);
    fault = 2'h3;
    step(2);
    chk(fflag, 8'h0);
    fault = 2'h0;
    sleep = 1'b0;
    wait_dly(2'h3, NC - 4, NC + 6);
    cfg = {4'h9, 4'h9};
    sleep = 1'b1;
    step(3);
    chk({con, dflag}, 8'hc);
    fault = 2'h1;
    step(1);
    fault = 2'h0;
    chk(fflag, 8'h1);
    fclr = 2'h1;
    step(1);
    fclr = 2'h0;
    chk(fflag, 8'h0);
    sleep = 1'b0;
    cfg = {4'h8, 4'h8};
  endtask
  // power-up clear restarts both masks
  task automatic t_pclr();
    pclr = 1'b1;
    step(1);
    pclr = 1'b0;
    step(2);
    fault = 2'h3;
    step(1);
    fault = 2'h0;
    chk(fflag, 8'h0);
    wait_dly(2'h3, NC - 6, NC + 6);
  endtask
  // main sequence
  initial begin
    step(6);
    resetn = 1'b1;
    t_reset();
    t_fault();
    t_mode();
    t_sleep();
    t_pclr();
    stop_test();
  end
endmodule
`default_nettype wire
